// *** shared/cssu_pkg.sv ***
package cssu_pkg;
    localparam int        XLEN           = 64;
    localparam int        WORD           = 32;
    localparam int        IMM_W          = 16;
    localparam int        SHAMT_W        = 5;
    localparam logic [5:0] OPC_REGOP     = 6'h00;
    localparam logic [5:0] OPC_CMP_IMM   = 6'h0B;
    localparam logic [5:0] OPC_SYSCOP    = 6'h10;
    localparam logic [5:0] FN_CMP_REG    = 6'h2B;
    localparam logic [5:0] FN_SHR_A      = 6'h03;
    localparam logic [5:0] FN_SHR_AV     = 6'h07;
    localparam logic [5:0] FN_SHR_L      = 6'h02;
    localparam logic [5:0] FN_SHR_LV     = 6'h06;
    localparam logic [5:0] FN_SUB        = 6'h22;
    localparam logic [5:0] FN_SUBNT      = 6'h23;
    localparam logic [5:0] FN_STANDBY    = 6'h21;
    localparam int        OPC_HI         = 31;
    localparam int        OPC_LO         = 26;
    localparam int        COP_BIT        = 25;
    localparam int        FN_HI          = 5;
    localparam int        SA_HI          = 10;
    localparam int        SA_LO          = 6;

    typedef enum logic [1:0] {
        CSSU_FULL    = 2'b00,
        CSSU_DRAIN   = 2'b01,
        CSSU_STANDBY = 2'b10
    } cssu_mode_t;
endpackage : cssu_pkg

// *** logic/cssu_unit.sv ***
`timescale 1ns/100ps
// How it works
// - immediate compare: sign-extend 16-bit immediate, unsigned less-than gives one
// - register compare, function 101011: first source below second gives one
// - compares never raise overflow; result correct despite subtraction overflow
// - fixed arithmetic right shift by shift amount field, sign fill
// - variable arithmetic right shift by low five bits of first source
// - fixed logical right shift by shift amount field, zero fill
// - variable logical right shift by low five bits, zero fill
// - coprocessor standby instruction starts move to standby mode
// - after writeback wait for idle system bus, then stop core clock
// - pll, timer, interrupt and bus clocks keep running in standby
// - any interrupt, nmi, warm or power-on reset leaves standby
// - trapping subtract overflows when carries out of bits 30, 31 differ
// - on overflow the destination is not written
// - trapping subtract, function 100010, writes first minus second
// - non-trapping subtract gives same difference, never traps
module cssu_unit #(
    parameter int XLEN = cssu_pkg::XLEN
) (
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    input  wire logic            issue_valid,
    input  wire logic [31:0]     instr_word,
    input  wire logic [XLEN-1:0] first_source_val,
    input  wire logic [XLEN-1:0] second_source_val,
    input  wire logic            mode64,
    input  wire logic            system_coproc_major_code_usable,
    input  wire logic            writeback_stage_done,
    input  wire logic            bus_idle_pin,
    input  wire logic            irq_pin,
    input  wire logic            nmi_pin,
    input  wire logic            warm_reset_request,
    input  wire logic            power_on_reset_request,
    output logic                 result_valid,
    output logic [XLEN-1:0]      result_data,
    output logic                 overflow_exc,
    output logic                 cop_unusable_exc,
    output logic                 core_clk_en,
    output logic                 periph_clk_en,
    output logic                 standby_mode
);
    localparam int W = cssu_pkg::WORD;

    // pin synchronisers
    logic [4:0] sync1;
    logic [4:0] sync2;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {bus_idle_pin, irq_pin, nmi_pin, warm_reset_request,
                      power_on_reset_request};
            sync2 <= sync1;
        end
    end
    wire bus_idle_s = sync2[4];
    wire wake_s     = |sync2[3:0];

    // decode
    wire [5:0] opc = instr_word[cssu_pkg::OPC_HI:cssu_pkg::OPC_LO];
    wire [5:0] fn  = instr_word[cssu_pkg::FN_HI:0];
    wire [cssu_pkg::SHAMT_W-1:0] shift_amount_field =
        instr_word[cssu_pkg::SA_HI:cssu_pkg::SA_LO];
    wire [cssu_pkg::IMM_W-1:0] imm = instr_word[cssu_pkg::IMM_W-1:0];
    wire regop = issue_valid && (opc == cssu_pkg::OPC_REGOP);
    wire is_cmp_imm = issue_valid && (opc == cssu_pkg::OPC_CMP_IMM);
    wire is_cmp_reg = regop && (fn == cssu_pkg::FN_CMP_REG);
    wire is_shr_a   = regop && (fn == cssu_pkg::FN_SHR_A);
    wire is_shr_av  = regop && (fn == cssu_pkg::FN_SHR_AV);
    wire is_shr_l   = regop && (fn == cssu_pkg::FN_SHR_L);
    wire is_shr_lv  = regop && (fn == cssu_pkg::FN_SHR_LV);
    wire is_sub   = regop && (fn == cssu_pkg::FN_SUB);
    wire is_subnt = regop && (fn == cssu_pkg::FN_SUBNT);
    wire is_stby  = issue_valid && (opc == cssu_pkg::OPC_SYSCOP)
                    && instr_word[cssu_pkg::COP_BIT]
                    && (fn == cssu_pkg::FN_STANDBY);

    // unsigned compares, plain magnitude so no overflow path
    wire [XLEN-1:0] imm_sx = {{(XLEN-cssu_pkg::IMM_W){imm[cssu_pkg::IMM_W-1]}},
                              imm};
    wire lt_imm = first_source_val < imm_sx;
    wire lt_reg = first_source_val < second_source_val;

    // shifts on the low word, result sign-extended to register width
    wire [cssu_pkg::SHAMT_W-1:0] var_amt =
        first_source_val[cssu_pkg::SHAMT_W-1:0];
    wire [cssu_pkg::SHAMT_W-1:0] amt = (is_shr_av || is_shr_lv) ? var_amt
                                                       : shift_amount_field;
    wire [W-1:0] opw = second_source_val[W-1:0];
    wire [W-1:0] shr_arith_w = $signed(opw) >>> amt;
    wire [W-1:0] shr_logic_w = opw >> amt;
    wire [W-1:0] sh_w = (is_shr_a || is_shr_av) ? shr_arith_w : shr_logic_w;
    wire [XLEN-1:0] sh_x = {{(XLEN-W){sh_w[W-1]}}, sh_w};

    // subtract with carries out of bits 30 and 31
    wire [W-1:0] a = first_source_val[W-1:0];
    wire [W-1:0] nb = ~second_source_val[W-1:0];
    wire [W-1:0] low_sum = {1'b0, a[W-2:0]} + {1'b0, nb[W-2:0]} + 32'h00000001;
    wire c30 = low_sum[W-1];
    wire [1:0] top = {1'b0, a[W-1]} + {1'b0, nb[W-1]} + {1'b0, c30};
    wire c31 = top[1];
    wire [W-1:0] diff = {top[0], low_sum[W-2:0]};
    wire ovf = is_sub && (c30 != c31);
    wire [XLEN-1:0] diff_x = {{(XLEN-W){diff[W-1]}}, diff};

    wire alu_op = is_cmp_imm || is_cmp_reg || is_shr_a || is_shr_av
                  || is_shr_l || is_shr_lv || is_sub || is_subnt;
    wire [XLEN-1:0] next_result =
        is_cmp_imm ? {{(XLEN-1){1'b0}}, lt_imm} :
        is_cmp_reg ? {{(XLEN-1){1'b0}}, lt_reg} :
        (is_sub || is_subnt) ? diff_x : sh_x;
    wire next_valid = alu_op && !ovf;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            result_valid <= 1'b0;
            result_data  <= '0;
            overflow_exc <= 1'b0;
        end else begin
            result_valid <= next_valid;
            overflow_exc <= ovf;
            if (next_valid) begin
                result_data <= next_result;
            end
        end
    end

    // standby sequencing
    cssu_pkg::cssu_mode_t mode;
    cssu_pkg::cssu_mode_t next_mode;
    logic pending;
    wire stby_ok  = is_stby && system_coproc_major_code_usable;
    wire stby_bad = is_stby && !system_coproc_major_code_usable;

    always_comb begin
        next_mode = mode;
        case (mode)
            cssu_pkg::CSSU_FULL: begin
                if (pending && writeback_stage_done) begin
                    next_mode = cssu_pkg::CSSU_DRAIN;
                end
            end
            cssu_pkg::CSSU_DRAIN: begin
                if (bus_idle_s) begin
                    next_mode = cssu_pkg::CSSU_STANDBY;
                end
            end
            cssu_pkg::CSSU_STANDBY: begin
                if (wake_s) begin
                    next_mode = cssu_pkg::CSSU_FULL;
                end
            end
            default: next_mode = cssu_pkg::CSSU_FULL;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode             <= cssu_pkg::CSSU_FULL;
            pending          <= 1'b0;
            cop_unusable_exc <= 1'b0;
            core_clk_en      <= 1'b1;
            periph_clk_en    <= 1'b1;
            standby_mode     <= 1'b0;
        end else begin
            mode             <= next_mode;
            cop_unusable_exc <= stby_bad;
            if (stby_ok) begin
                pending <= 1'b1;
            end else if (mode == cssu_pkg::CSSU_FULL && writeback_stage_done) begin
                pending <= 1'b0;
            end
            core_clk_en   <= (next_mode != cssu_pkg::CSSU_STANDBY);
            periph_clk_en <= 1'b1;
            standby_mode  <= (next_mode == cssu_pkg::CSSU_STANDBY);
        end
    end

    a_ovf_blocks_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        overflow_exc |-> !result_valid)
        else $error("overflow with result write");
    a_subnt_no_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_subnt |=> !overflow_exc && result_valid)
        else $error("non-trapping subtract trapped");
    a_cmp_zero_ext: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_cmp_reg || is_cmp_imm) |=> result_valid
            && result_data[XLEN-1:1] == '0 && !overflow_exc)
        else $error("compare result not zero-extended");
    a_cmp_reg_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_cmp_reg |=> result_data[0] == $past(lt_reg))
        else $error("register compare wrong");
    a_shr_zero_fill: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_shr_l && shift_amount_field != 5'h00)
            |=> !result_data[W-1])
        else $error("logical shift filled ones");
    a_shr_sign_fill: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_shr_a && second_source_val[W-1]) |=> result_data[W-1])
        else $error("arithmetic shift lost sign");
    a_stby_clk_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == cssu_pkg::CSSU_DRAIN && bus_idle_s) |=> !core_clk_en
            && standby_mode && periph_clk_en)
        else $error("core clock not stopped");
    a_wake_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mode == cssu_pkg::CSSU_STANDBY && wake_s) |=> core_clk_en
            && !standby_mode)
        else $error("standby not left on wake");
    a_cop_unusable: assert property (@(posedge core_clk) disable iff (!rst_n)
        stby_bad |=> cop_unusable_exc ##1 mode == cssu_pkg::CSSU_FULL)
        else $error("unusable standby not refused");
endmodule : cssu_unit

// *** dv/cssu_pipe_model.sv ***
`timescale 1ns/100ps
module cssu_pipe_model (
    input  wire logic                       core_clk,
    output logic                            issue_valid,
    output logic [31:0]                     instr_word,
    output logic [cssu_pkg::XLEN-1:0]       first_source_val,
    output logic [cssu_pkg::XLEN-1:0]       second_source_val
);
    initial begin
        issue_valid = 1'b0;
        instr_word = 32'h0000_0000;
        first_source_val = 64'h0;
        second_source_val = 64'h0;
    end

    // one instruction held for one edge, then released
    task automatic issue(input logic [31:0] iw, input logic [31:0] a,
                         input logic [31:0] b);
        @(negedge core_clk);
        issue_valid = 1'b1;
        instr_word = iw;
        first_source_val = {{32{a[31]}}, a};
        second_source_val = {{32{b[31]}}, b};
        @(negedge core_clk);
        issue_valid = 1'b0;
        instr_word = ~iw;
        first_source_val = ~first_source_val;
        second_source_val = ~second_source_val;
    endtask : issue
endmodule : cssu_pipe_model

// *** dv/compare_shift_subtract_unit_tb.sv ***
`timescale 1ns/100ps
module compare_shift_subtract_unit_tb;
    logic        core_clk, rst_n, system_coproc_major_code_usable, wb_done, bus_idle, iv;
    logic [3:0]  wake;
    logic [31:0] iw;
    logic [63:0] a, b, rd;
    logic        rv, ov, cu, clk_en, per_en, stby, frv, fov, fcu;
    int          errors, checks_done, cycles;

    cssu_pipe_model model (.core_clk(core_clk), .issue_valid(iv),
        .instr_word(iw), .first_source_val(a), .second_source_val(b));
    cssu_unit dut (.core_clk(core_clk), .rst_n(rst_n), .issue_valid(iv),
        .instr_word(iw), .first_source_val(a), .second_source_val(b),
        .mode64(1'b1), .system_coproc_major_code_usable(system_coproc_major_code_usable),
        .writeback_stage_done(wb_done), .bus_idle_pin(bus_idle),
        .irq_pin(wake[0]), .nmi_pin(wake[1]),
        .warm_reset_request(wake[2]), .power_on_reset_request(wake[3]),
        .result_valid(rv), .result_data(rd), .overflow_exc(ov),
        .cop_unusable_exc(cu), .core_clk_en(clk_en),
        .periph_clk_en(per_en), .standby_mode(stby));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    function automatic logic [31:0] rop(logic [5:0] fn, logic [4:0] sa);
        return {6'h00, 15'h0, sa, fn};
    endfunction : rop

    // issue and catch whichever one-cycle answer comes back
    task automatic run(input logic [31:0] w, input logic [31:0] x,
                       input logic [31:0] y);
        model.issue(w, x, y);
        {frv, fov, fcu} = 3'b000;
        for (int i = 0; i < 3; i++) begin
            if ((rv | ov | cu) === 1'b1) begin
                {frv, fov, fcu} = {rv, ov, cu};
                break;
            end
            @(negedge core_clk);
        end
    endtask : run

    task automatic res(input logic [31:0] w, input logic [31:0] x,
                       input logic [31:0] y, input logic [63:0] e);
        run(w, x, y);
        check(frv, 1'b1);
        check(fov, 1'b0);
        check(rd, e);
    endtask : res

    task automatic t_compare;
        res({6'h0B, 10'h0, 16'hFFFF}, 32'h5, 0, 64'h1);
        res({6'h0B, 10'h0, 16'h0003}, 32'h5, 0, 64'h0);
        res(rop(6'h2B, 0), 32'h1, 32'h8000_0000, 64'h1);
        res(rop(6'h2B, 0), 32'h8000_0000, 32'h1, 64'h0);
    endtask : t_compare

    task automatic t_shift;
        res(rop(6'h03, 4), 0, 32'h8000_0010,
            64'hFFFF_FFFF_F800_0001);
        res(rop(6'h07, 0), 32'h28, 32'h8000_0010,
            64'hFFFF_FFFF_FF80_0000);
        res(rop(6'h02, 4), 0, 32'h8000_0010, 64'h0800_0001);
        res(rop(6'h06, 0), 32'h28, 32'h8000_0010, 64'h0080_0000);
    endtask : t_shift

    task automatic t_subtract;
        res(rop(6'h22, 0), 32'h5, 32'h7,
            64'hFFFF_FFFF_FFFF_FFFE);
        run(rop(6'h22, 0), 32'h8000_0000, 32'h1);
        check({frv, fov}, 2'b01);
        check(rd, 64'hFFFF_FFFF_FFFF_FFFE);
        run(rop(6'h22, 0), 32'h7FFF_FFFF, 32'hFFFF_FFFF);
        check({frv, fov}, 2'b01);
        res(rop(6'h23, 0), 32'h8000_0000, 32'h1, 64'h7FFF_FFFF);
    endtask : t_subtract

    task automatic t_standby;
        system_coproc_major_code_usable = 1'b0;
        run({6'h10, 1'b1, 19'h0, 6'h21}, 0, 0);
        check(fcu, 1'b1);
        check(stby, 1'b0);
        system_coproc_major_code_usable = 1'b1;
        for (int w = 0; w < 4; w++) begin
            run({6'h10, 1'b1, 19'h0, 6'h21}, 0, 0);
            wb_done = 1'b1;
            @(negedge core_clk);
            wb_done = 1'b0;
            repeat (5) @(negedge core_clk);
            check(stby, 1'b0);
            bus_idle = 1'b1;
            for (int i = 0; i < 6 && stby !== 1'b1; i++) @(negedge core_clk);
            check({stby, clk_en}, 2'b10);
            check(per_en, 1'b1);
            bus_idle = 1'b0;
            wake[w] = 1'b1;
            for (int i = 0; i < 6 && stby !== 1'b0; i++) @(negedge core_clk);
            check({stby, clk_en}, 2'b01);
            wake[w] = 1'b0;
            repeat (4) @(negedge core_clk);
        end
    endtask : t_standby

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        {errors, checks_done, cycles} = '0;
        {rst_n, wb_done, bus_idle, wake} = '0;
        system_coproc_major_code_usable = 1'b1;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check({rv, ov, cu, clk_en, per_en, stby}, 6'b000110);
        t_compare();
        t_shift();
        t_subtract();
        t_standby();
        tally_and_finish();
    end
endmodule : compare_shift_subtract_unit_tb
